// [hw/isc_defines.svh]
// constants: offsets, field positions, reset values, vectors and timing counts
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH
// register offsets on the plain register port
`define ISC_REG_SHIFT_MODE  4'h0
`define ISC_REG_STATUS      4'h4
// shift configuration register
`define ISC_SHIFT_MODE_RST  4'h0
`define ISC_SERIAL_SEL_BIT  3
// status register field positions
`define ISC_ST_TMR_BIT      0
`define ISC_ST_SHR_BIT      1
`define ISC_ST_EXT2_BIT     2
`define ISC_ST_IME_BIT      3
`define ISC_ST_HALT_BIT     4
`define ISC_ST_STOP_BIT     5
`define ISC_ST_BUSY_BIT     6
// vector addresses
`define ISC_VEC_TIMER       12'h010
`define ISC_VEC_SHARED      12'h020
`define ISC_VEC_EXT2        12'h030
`define ISC_VEC_RESET       12'h000
// test-and-clear flag selection codes
`define ISC_SEL_TMR         2'h0
`define ISC_SEL_SHR         2'h1
`define ISC_SEL_EXT2        2'h2
// serial byte length
`define ISC_BYTE_BITS       8
// oscillator stabilisation wait
`define ISC_CLK_PERIOD_NS   50
`define ISC_STAB_WAIT_NS    62500000
`define ISC_STAB_CYCLES ((`ISC_STAB_WAIT_NS + `ISC_CLK_PERIOD_NS - 1) / `ISC_CLK_PERIOD_NS)
`endif

// [hw/isc_pkg.sv]
// types shared by the interrupt and standby control block
package isc_pkg;
   typedef enum logic [2:0] {
      isc_st_idle = 3'b001,
      isc_st_save = 3'b010,
      isc_st_jump = 3'b100
   } isc_state_e;

   typedef struct packed {
      logic tmr;
      logic shr;
      logic ext2;
   } isc_flags_s;

   typedef struct packed {
      logic       boundary;
      logic       set_master_enable;
      logic       clear_master_enable;
      logic       halt_instr;
      logic       stop_instr;
      logic       shift_one_byte_instr;
      logic       test_and_clear_flag_instr;
      logic [1:0] test_sel;
   } isc_cpu_req_s;

   typedef struct packed {
      logic        save;
      logic        jump;
      logic        exec_start;
      logic [11:0] addr;
   } isc_vec_s;
endpackage

// [hw/isc_serial_count.sv]
// byte-transfer counter driving the serial clock pin
`timescale 1ns/1ns
`include "isc_defines.svh"
module isc_serial_count #(
   parameter int BITS = `ISC_BYTE_BITS
) (
   input  logic clk,
   input  logic rst_n,
   input  logic start,
   input  logic cpu_run,
   output logic sck_out,
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [2:0] cnt;
      logic       busy;
      logic       sck;
      logic       done;
   } isc_ser_s;

   isc_ser_s s_reg;
   isc_ser_s s_next;

   initial begin
      if (BITS != 8) $error("isc_serial_count: counter is 3 bits, BITS must be 8");
   end

   always_comb begin
      s_next      = s_reg;
      s_next.done = 1'b0;
      if (!s_reg.busy) begin
         s_next.busy = start;
         s_next.cnt  = 3'h0;
      // R13 paused in halt
      end else if (cpu_run) begin
         if (s_reg.sck) begin
            s_next.sck = 1'b0;
         end else begin
            // R6 count clock pulses
            s_next.sck = 1'b1;
            s_next.cnt = s_reg.cnt + 3'h1;
            // R7 stop after eighth
            if (s_reg.cnt == 3'h7) begin
               s_next.busy = 1'b0;
               s_next.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{cnt: 3'h0, busy: 1'b0, sck: 1'b1, done: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign sck_out = s_reg.sck;
   assign busy    = s_reg.busy;
   assign done    = s_reg.done;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sck_idle_high_a: assert property (!busy |-> sck_out) else $error("sck not high when idle"); // R7
   byte_len_a: assert property ($rose(busy) |-> busy[*8]) else $error("transfer too short"); // R6
   done_end_a: assert property ($fell(busy) |-> done && sck_out) else $error("done missing"); // R6
   byte_done_c: cover property (done);
endmodule // isc_serial_count

// [hw/isc_standby.sv]
// halt and stop flip-flops with the oscillator stabilisation wait
`timescale 1ns/1ns
`include "isc_defines.svh"
module isc_standby #(
   parameter int STAB_CYCLES = `ISC_STAB_CYCLES,
   parameter int CW          = 21
) (
   input  logic clk,
   input  logic rst_n,
   input  logic halt_req,
   input  logic stop_req,
   input  logic pending,
   input  logic release_pulse,
   output logic halted,
   output logic stopped,
   output logic internal_reset_n,
   output logic exec_start
);
   typedef struct packed {
      logic          halt;
      logic          stop;
      logic          waiting;
      logic          start;
      logic [CW-1:0] cnt;
   } isc_sby_s;

   isc_sby_s s_reg;
   isc_sby_s s_next;

   initial begin
      if (STAB_CYCLES < 1 || STAB_CYCLES >= (1 << CW))
         $error("isc_standby: STAB_CYCLES does not fit the wait counter");
   end

   always_comb begin
      s_next       = s_reg;
      s_next.start = 1'b0;
      if (s_reg.waiting) begin
         // R18 wait, then run
         if (s_reg.cnt == CW'(STAB_CYCLES - 1)) begin
            s_next.waiting = 1'b0;
            s_next.halt    = 1'b0;
            s_next.start   = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt + {{(CW-1){1'b0}}, 1'b1};
         end
      end else if (stop_req) begin
         // R16 stop all clocks
         s_next.stop = 1'b1;
         s_next.halt = 1'b1;
      // R14 refuse halt if pending
      // a flag landing in the halt cycle itself would otherwise leave the core asleep
      end else if (halt_req && !pending && !release_pulse) begin
         s_next.halt = 1'b1;
      // R15 R20 flag releases halt
      end else if (release_pulse && !s_reg.stop) begin
         s_next.halt = 1'b0;
      end
   end

   // R17 reset enters halt, clears stop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{halt: 1'b1, stop: 1'b0, waiting: 1'b1, start: 1'b0, cnt: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign halted           = s_reg.halt;
   assign stopped          = s_reg.stop;
   assign internal_reset_n = !s_reg.waiting;
   assign exec_start       = s_reg.start;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   halt_refuse_a: assert property (!halted && !stopped && !stop_req && halt_req && pending
      && internal_reset_n |=> !halted) else $error("halt entered with pending flag"); // R14
   halt_wake_a: assert property (halted && !stopped && internal_reset_n && release_pulse
      && !stop_req |=> !halted) else $error("halt not released by flag"); // R15
   stop_hold_a: assert property (stopped |=> stopped && halted)
      else $error("stop left without reset"); // R16
   wait_end_a: assert property ($rose(internal_reset_n) |-> exec_start && !halted)
      else $error("execution not started after wait"); // R18
   halt_release_c: cover property ($fell(halted) && !exec_start);
   stop_enter_c: cover property ($rose(stopped));
endmodule // isc_standby

// [hw/isc_top.sv]
// interrupt arbitration, vectoring and standby control top level
//
// How it works
// R1: four sources: timer, port zero, serial, second
// R2: vectors 16, 32 and 48
// R3: timer first, shared second, second pin third
// R4: port zero and serial share one flag
// R5: select bit zero picks serial done
// R6: 3-bit counter flags each finished byte
// R7: shift instruction sends eight clocks, then high
// R8: set, disable, push, jump, then clear flag
// R9: entry takes two machine cycles
// R10: all flags set, highest served, others wait
// R11: test-and-clear polls and clears a flag
// R12: halt stops only the cpu clock
// R13: serial pauses in halt, cpu-clocked shift
// R14: halt refused while any flag pending
// R15: reset or new flag ends halt
// R16: stop freezes all, only reset ends it
// R17: reset enters halt, release starts wait
// R18: after wait leave halt, run at zero
// R19: memory kept, other registers undefined
// R20: halt flip-flop cleared by release or reset; here reset sets it and the end of the wait clears it
// R21: vector only while master enable set
// R22: core acknowledges only at instruction boundaries
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "isc_defines.svh"
module isc_top #(
   parameter int STAB_CYCLES = `ISC_STAB_CYCLES
) (
   input  logic                  clk,
   input  logic                  rst_n,
   input  logic [3:0]            reg_addr,
   input  logic [7:0]            reg_wdata,
   input  logic                  reg_wr,
   input  logic                  reg_rd,
   output logic [7:0]            reg_rdata,
   input  logic                  timer_match_interrupt,
   input  logic                  port_zero_pin,
   input  logic                  second_ext_pin,
   input  isc_pkg::isc_cpu_req_s cpu_req,
   output isc_pkg::isc_vec_s     int_vec,
   output logic                  test_flag_hit,
   output logic                  cpu_clk_en,
   output logic                  sck_out,
   output logic                  halted,
   output logic                  stopped,
   output logic                  internal_reset_signal_n
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0]           p0_sync;
      logic [1:0]           e2_sync;
      logic                 p0_prev;
      logic                 e2_prev;
      isc_pkg::isc_flags_s  flags;
      isc_pkg::isc_flags_s  serving;
      logic                 ime;
      isc_pkg::isc_state_e  state;
      logic                 mphase;
      logic                 phi;
      logic [3:0]           shift_mode;
      logic [7:0]           rdata;
      logic                 test_hit;
      isc_pkg::isc_vec_s    vec;
   } isc_main_s;

   isc_main_s s_reg;
   isc_main_s s_next;

   logic                serial_done;
   logic                serial_busy;
   logic                exec_start;
   logic                cpu_run;
   isc_pkg::isc_flags_s set_evt;
   isc_pkg::isc_flags_s clr_mask;
   logic                p0_rise;
   logic                e2_rise;
   logic                accept;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic isc_pkg::isc_flags_s pick(input isc_pkg::isc_flags_s f);
      isc_pkg::isc_flags_s r;
      r = '0;
      // R3 fixed priority
      if (f.tmr) begin
         r.tmr = 1'b1;
      end else if (f.shr) begin
         r.shr = 1'b1;
      end else if (f.ext2) begin
         r.ext2 = 1'b1;
      end
      return r;
   endfunction

   function automatic logic [11:0] vec_of(input isc_pkg::isc_flags_s f);
      logic [11:0] a;
      a = `ISC_VEC_EXT2;
      // R2 vector per source
      if (f.tmr) begin
         a = `ISC_VEC_TIMER;
      end else if (f.shr) begin
         a = `ISC_VEC_SHARED;
      end
      return a;
   endfunction

   function automatic isc_pkg::isc_flags_s sel_mask(input logic [1:0] sel);
      isc_pkg::isc_flags_s m;
      m      = '0;
      m.tmr  = (sel == `ISC_SEL_TMR);
      m.shr  = (sel == `ISC_SEL_SHR);
      m.ext2 = (sel == `ISC_SEL_EXT2);
      return m;
   endfunction

   // ------------------------------------------------------------
   // submodules
   // ------------------------------------------------------------
   // R12 phi gated by halt only
   assign cpu_run = s_reg.phi && !halted;

   isc_serial_count #(
      .BITS (`ISC_BYTE_BITS)
   ) u_serial (
      .clk     (clk),
      .rst_n   (rst_n),
      .start   (cpu_req.shift_one_byte_instr && cpu_run),
      .cpu_run (cpu_run),
      .sck_out (sck_out),
      .busy    (serial_busy),
      .done    (serial_done)
   );

   isc_standby #(
      .STAB_CYCLES (STAB_CYCLES),
      .CW          (21)
   ) u_standby (
      .clk              (clk),
      .rst_n            (rst_n),
      .halt_req         (cpu_req.halt_instr && cpu_run),
      .stop_req         (cpu_req.stop_instr && cpu_run),
      .pending          (s_reg.flags != '0),
      .release_pulse    (set_evt != '0),
      .halted           (halted),
      .stopped          (stopped),
      .internal_reset_n (internal_reset_signal_n),
      .exec_start       (exec_start)
   );

   // ------------------------------------------------------------
   // request flags
   // ------------------------------------------------------------
   // pins are read only after the second synchroniser stage
   assign p0_rise = s_reg.p0_sync[1] && !s_reg.p0_prev;
   assign e2_rise = s_reg.e2_sync[1] && !s_reg.e2_prev;

   always_comb begin
      set_evt = '0;
      // R1 four sources, none while stopped
      if (!stopped) begin
         set_evt.tmr  = timer_match_interrupt;
         // R4 R5 shared flag source
         set_evt.shr  = s_reg.shift_mode[`ISC_SERIAL_SEL_BIT] ? p0_rise : serial_done;
         set_evt.ext2 = e2_rise;
      end
   end

   always_comb begin
      clr_mask = '0;
      // R11 test-and-clear
      if (cpu_req.test_and_clear_flag_instr && cpu_run) begin
         clr_mask = sel_mask(cpu_req.test_sel);
      end
      // R8 serviced flag cleared last
      if (s_reg.state == isc_pkg::isc_st_jump && s_reg.mphase) begin
         clr_mask = isc_pkg::isc_flags_s'(clr_mask | s_reg.serving);
      end
   end

   // R21 vector only with master enable
   assign accept = s_reg.state == isc_pkg::isc_st_idle && s_reg.ime && s_reg.flags != '0
                   && cpu_req.boundary && cpu_run;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_next            = s_reg;
      s_next.p0_sync    = {s_reg.p0_sync[0], port_zero_pin};
      s_next.e2_sync    = {s_reg.e2_sync[0], second_ext_pin};
      s_next.p0_prev    = s_reg.p0_sync[1];
      s_next.e2_prev    = s_reg.e2_sync[1];
      s_next.phi        = stopped ? s_reg.phi : !s_reg.phi;
      s_next.rdata      = 8'h00;
      s_next.vec.exec_start = exec_start;
      // R10 set wins over clear, all flags kept
      s_next.flags = isc_pkg::isc_flags_s'((s_reg.flags & ~clr_mask) | set_evt);
      if (cpu_req.test_and_clear_flag_instr && cpu_run) begin
         s_next.test_hit = |(s_reg.flags & sel_mask(cpu_req.test_sel));
      end
      if (cpu_req.set_master_enable && cpu_run) begin
         s_next.ime = 1'b1;
      end else if (cpu_req.clear_master_enable && cpu_run) begin
         s_next.ime = 1'b0;
      end
      // R18 execution starts at zero
      if (exec_start) begin
         s_next.vec.addr = `ISC_VEC_RESET;
      end
      // R8 R9 two machine cycles of entry
      case (s_reg.state)
         isc_pkg::isc_st_idle: begin
            if (accept) begin
               s_next.ime     = 1'b0;
               s_next.serving = pick(s_reg.flags);
               s_next.state   = isc_pkg::isc_st_save;
               s_next.mphase  = 1'b0;
               s_next.vec.save = 1'b1;
            end
         end
         isc_pkg::isc_st_save: begin
            s_next.mphase = !s_reg.mphase;
            if (s_reg.mphase) begin
               s_next.state    = isc_pkg::isc_st_jump;
               s_next.vec.save = 1'b0;
               s_next.vec.jump = 1'b1;
               s_next.vec.addr = vec_of(s_reg.serving);
            end
         end
         isc_pkg::isc_st_jump: begin
            s_next.mphase = !s_reg.mphase;
            if (s_reg.mphase) begin
               s_next.state    = isc_pkg::isc_st_idle;
               s_next.vec.jump = 1'b0;
               s_next.serving  = '0;
            end
         end
         default: begin
            s_next.state    = isc_pkg::isc_st_idle;
            s_next.vec.save = 1'b0;
            s_next.vec.jump = 1'b0;
         end
      endcase
      // ------------------------------------------------------------
      // register port
      // ------------------------------------------------------------
      if (reg_wr && reg_addr == `ISC_REG_SHIFT_MODE) begin
         s_next.shift_mode = reg_wdata[3:0];
      end
      if (reg_rd) begin
         case (reg_addr)
            `ISC_REG_SHIFT_MODE: s_next.rdata = {4'h0, s_reg.shift_mode};
            `ISC_REG_STATUS: begin
               s_next.rdata[`ISC_ST_TMR_BIT]  = s_reg.flags.tmr;
               s_next.rdata[`ISC_ST_SHR_BIT]  = s_reg.flags.shr;
               s_next.rdata[`ISC_ST_EXT2_BIT] = s_reg.flags.ext2;
               s_next.rdata[`ISC_ST_IME_BIT]  = s_reg.ime;
               s_next.rdata[`ISC_ST_HALT_BIT] = halted;
               s_next.rdata[`ISC_ST_STOP_BIT] = stopped;
               s_next.rdata[`ISC_ST_BUSY_BIT] = serial_busy;
            end
            default: s_next.rdata = 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // R19 only data memory survives, so everything here restarts
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '{p0_sync: 2'h0, e2_sync: 2'h0, p0_prev: 1'b0, e2_prev: 1'b0,
                    flags: '0, serving: '0, ime: 1'b0, state: isc_pkg::isc_st_idle,
                    mphase: 1'b0, phi: 1'b0, shift_mode: `ISC_SHIFT_MODE_RST,
                    rdata: 8'h00, test_hit: 1'b0, vec: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata     = s_reg.rdata;
   assign int_vec       = s_reg.vec;
   assign test_flag_hit = s_reg.test_hit;
   assign cpu_clk_en    = cpu_run;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   ime_clear_a: assert property (accept |=> !s_reg.ime && int_vec.save) // R8
      else $error("master enable not cleared on entry");
   entry_seq_a: assert property ($rose(int_vec.save) |-> int_vec.save[*2]
      ##1 int_vec.jump[*2] ##1 !int_vec.jump) else $error("entry not two machine cycles"); // R9
   vector_a: assert property ($rose(int_vec.jump) |-> int_vec.addr ==
      (s_reg.serving.tmr ? 12'h010 : s_reg.serving.shr ? 12'h020 : 12'h030))
      else $error("wrong vector address"); // R2
   prio_a: assert property (accept && s_reg.flags.tmr |=> s_reg.serving.tmr)
      else $error("timer not served first"); // R3
   shared_src_a: assert property (serial_done && !stopped
      && !s_reg.shift_mode[`ISC_SERIAL_SEL_BIT] |=> s_reg.flags.shr)
      else $error("serial done did not set shared flag"); // R5
   no_ime_a: assert property (!s_reg.ime && s_reg.state == isc_pkg::isc_st_idle
      |=> !int_vec.save) else $error("vectored without master enable"); // R21
   pend_keep_a: assert property ($fell(int_vec.jump) && $past(s_reg.flags.ext2)
      && !$past(s_reg.serving.ext2) && !$past(clr_mask.ext2) |-> s_reg.flags.ext2)
      else $error("pending flag lost"); // R10
   test_clr_a: assert property (cpu_req.test_and_clear_flag_instr && cpu_run
      && cpu_req.test_sel == 2'h0 && !timer_match_interrupt |=> !s_reg.flags.tmr)
      else $error("test-and-clear left flag set"); // R11
   // a served flag is cleared at the end of entry unless its source fired again
   flag_clear_a: assert property ($fell(int_vec.jump) && $past(s_reg.serving.tmr) // R8
      && !$past(set_evt.tmr) |-> !s_reg.flags.tmr) else $error("served flag not cleared");
   // timer requests still land while the cpu clock is held
   tmr_halt_a: assert property (halted && !stopped && timer_match_interrupt // R12
      |=> s_reg.flags.tmr) else $error("timer flag lost in halt");
   // no flag moves while stopped and idle
   stop_freeze_a: assert property (stopped && s_reg.state == isc_pkg::isc_st_idle // R16
      |=> $stable(s_reg.flags)) else $error("flags changed in stop");
   exec_addr_a: assert property (exec_start |=> int_vec.exec_start // R18
      && int_vec.addr == `ISC_VEC_RESET) else $error("execution start not at zero");
   // pin sources only count edges seen after the synchroniser
   p0_src_a: assert property (p0_rise && !stopped // R5
      && s_reg.shift_mode[`ISC_SERIAL_SEL_BIT] |=> s_reg.flags.shr)
      else $error("port zero edge did not set shared flag");
   ext2_src_a: assert property (e2_rise && !stopped |=> s_reg.flags.ext2) // R1
      else $error("second pin edge did not set its flag");
   // set beats clear when both come in one phase
   ime_set_a: assert property (cpu_req.set_master_enable && cpu_run && !accept // R21
      |=> s_reg.ime) else $error("master enable not set");
   test_hit_a: assert property (cpu_req.test_and_clear_flag_instr && cpu_run // R11
      && cpu_req.test_sel == 2'h1 && s_reg.flags.shr |=> test_flag_hit)
      else $error("test-and-clear missed a set flag");
   entry_c: cover property ($rose(int_vec.jump));
   shared_entry_c: cover property (accept && s_reg.flags.shr && s_reg.flags.ext2);
endmodule // isc_top

// [test/isc_cpu_model.sv]
// cpu core sequencer model facing the interrupt block
`timescale 1ns/1ns
module isc_cpu_model (
   input  logic                  clk,
   input  logic                  rst_n,
   input  logic                  cpu_clk_en,
   input  logic                  hold_off,
   input  logic                  cmd_go,
   input  logic [8:0]            cmd,
   input  isc_pkg::isc_vec_s     int_vec,
   output isc_pkg::isc_cpu_req_s cpu_req
);
   isc_pkg::isc_cpu_req_s cmd_reg;
   // ----
   // instruction issue
   // ----
   // an instruction stays up until one cpu phase has taken it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= '0;
      end else if (cmd_go) begin
         cmd_reg <= cmd;
      end else if (cpu_clk_en) begin
         cmd_reg <= '0;
      end
   end
   // boundary between instructions only
   // hold_off models a long instruction that delays acknowledge
   always_comb begin
      cpu_req          = cmd_reg;
      cpu_req.boundary = !hold_off && !int_vec.save && !int_vec.jump;
   end
endmodule // isc_cpu_model

// [test/isc_top_tb_top.sv]
// self-checking bench for the interrupt and standby block
`timescale 1ns/1ns
`include "isc_defines.svh"
module isc_top_tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        timer_match_interrupt = 1'b0;
   logic        port_zero_pin = 1'b0;
   logic        second_ext_pin = 1'b0;
   logic        hold_off = 1'b0;
   logic        cmd_go = 1'b0;
   logic [8:0]  cmd = 9'h000;
   logic [7:0]  reg_rdata;
   logic [7:0]  d;
   logic [11:0] falls = 12'h000;
   logic [11:0] falls_base = 12'h000;
   logic [31:0] rnd = 32'h93E0;
   logic        test_flag_hit;
   logic        cpu_clk_en;
   logic        sck_out;
   logic        halted;
   logic        stopped;
   logic        internal_reset_signal_n;
   int          mismatches = 0;
   int          tests_run = 0;
   int          i;
   isc_pkg::isc_cpu_req_s cpu_req;
   isc_pkg::isc_vec_s     int_vec;

   always #25 clk = ~clk;
   always @(negedge sck_out) falls = falls + 12'h001;

   isc_top #(.STAB_CYCLES(20)) uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .timer_match_interrupt, .port_zero_pin, .second_ext_pin,
      .cpu_req, .int_vec, .test_flag_hit, .cpu_clk_en, .sck_out, .halted, .stopped,
      .internal_reset_signal_n);
   isc_cpu_model cpu_m (.clk, .rst_n, .cpu_clk_en, .hold_off, .cmd_go, .cmd,
      .int_vec, .cpu_req);

   // ----
   // helpers
   // ----
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // fixed priority: timer, then shared, then second pin
   function logic [11:0] vec_of(input logic [2:0] f);
      if (f[0]) return `ISC_VEC_TIMER;
      if (f[1]) return `ISC_VEC_SHARED;
      return `ISC_VEC_EXT2;
   endfunction
   task chk(input string n, input logic [11:0] s, input logic [11:0] e);
      tests_run++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task tick;
      @(posedge clk);
      #5;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #10 v = reg_rdata;
   endtask
   task cpu(input logic [8:0] c);
      @(posedge clk);
      cmd <= c;
      cmd_go <= 1'b1;
      @(posedge clk);
      cmd_go <= 1'b0;
      repeat (4) tick;
   endtask
   task tmr;
      @(posedge clk);
      timer_match_interrupt <= 1'b1;
      @(posedge clk);
      timer_match_interrupt <= 1'b0;
      repeat (3) tick;
   endtask
   task do_reset;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      tick;
   endtask
   task wait_exec;
      for (i = 0; i < 40 && int_vec.exec_start !== 1'b1; i++) tick;
      chk("start_addr", int_vec.addr, `ISC_VEC_RESET);
      chk("internal_reset_signal_n", internal_reset_signal_n, 1'b1);
      tick;
      chk("halted", halted, 1'b0);
   endtask
   task entry(input logic [2:0] f);
      int n;
      n = 0;
      hold_off <= 1'b0;
      for (i = 0; i < 40 && int_vec.jump !== 1'b1; i++) begin
         tick;
         if (int_vec.save === 1'b1) n++;
      end
      chk("save_cycles", n, 2);
      chk("vector", int_vec.addr, vec_of(f));
      repeat (4) tick;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----
   // scenarios
   // ----
   initial begin
      do_reset;
      chk("halted", halted, 1'b1);
      chk("internal_reset_signal_n", internal_reset_signal_n, 1'b0);
      wait_exec;
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         wr(4'h0, rnd[7:0]);
         rd(4'h0, d);
         chk("shift_mode", d, {4'h0, rnd[3:0]});
      end
      rd(4'hF, d);
      chk("unmapped", d, 8'h00);
      cpu(9'h020);
      chk("halted", halted, 1'b1);
      chk("cpu_clk_en", cpu_clk_en, 1'b0);
      tmr;
      chk("halted", halted, 1'b0);
      cpu(9'h020);
      chk("halted", halted, 1'b0);
      cpu(9'h004);
      chk("test_hit", test_flag_hit, 1'b1);
      rd(4'h4, d);
      chk("flags", d[3:0], 4'h0);
      second_ext_pin <= 1'b1;
      tmr;
      repeat (3) tick;
      rd(4'h4, d);
      chk("flags", d[3:0], 4'h5);
      chk("save", int_vec.save, 1'b0);
      hold_off <= 1'b1;
      cpu(9'h080);
      repeat (6) tick;
      chk("save", int_vec.save, 1'b0);
      entry(3'b101);
      rd(4'h4, d);
      chk("flags", d[3:0], 4'h4);
      second_ext_pin <= 1'b0;
      hold_off <= 1'b1;
      cpu(9'h080);
      entry(3'b100);
      wr(4'h0, 8'h00);
      falls_base = falls;
      cpu(9'h008);
      repeat (40) tick;
      chk("sck_falls", falls - falls_base, 12'h008);
      chk("sck_idle", sck_out, 1'b1);
      rd(4'h4, d);
      chk("flags", d[2:0], 3'h2);
      cpu(9'h005);
      chk("test_hit", test_flag_hit, 1'b1);
      wr(4'h0, 8'h08);
      port_zero_pin <= 1'b1;
      repeat (6) tick;
      port_zero_pin <= 1'b0;
      rd(4'h4, d);
      chk("flags", d[2:0], 3'h2);
      hold_off <= 1'b1;
      cpu(9'h080);
      entry(3'b010);
      cpu(9'h080);
      rd(4'h4, d);
      chk("ime", d[3], 1'b1);
      cpu(9'h040);
      rd(4'h4, d);
      chk("ime", d[3], 1'b0);
      cpu(9'h010);
      tmr;
      chk("stopped", stopped, 1'b1);
      chk("halted", halted, 1'b1);
      do_reset;
      chk("stopped", stopped, 1'b0);
      chk("halted", halted, 1'b1);
      wait_exec;
      complete_run;
   end

   initial begin
      #400000;
      mismatches++;
      complete_run;
   end
endmodule // isc_top_tb_top
